// >>> src/psrsc_pkg.sv
package psrsc_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] PSRSC_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] PSRSC_ADDR_EIEN   = 8'h04;
   localparam logic [7:0] PSRSC_ADDR_PWUEN  = 8'h08;
   localparam logic [7:0] PSRSC_ADDR_STATUS = 8'h0c;
   localparam logic [7:0] PSRSC_ADDR_RSTSRC = 8'h10;

   // Control register fields
   localparam int PSRSC_CTRL_HOLD = 0;
   localparam int PSRSC_CTRL_GATE = 1;

   // Status register fields
   localparam int PSRSC_ST_HELD  = 0;
   localparam int PSRSC_ST_CLS1  = 1;
   localparam int PSRSC_ST_CLS2  = 2;
   localparam int PSRSC_ST_CLS3  = 3;
   localparam int PSRSC_ST_INT   = 4;
   localparam int PSRSC_ST_MODE  = 8;

   localparam logic [31:0] PSRSC_RDATA_RST = 32'h0000_0000;

   // ****************************************
   // Reset source vector
   // ****************************************
   typedef struct packed {
      logic power_on_reset_src;
      logic ram_retention_lowv_reset;
      logic internal_supply_lowv_reset;
      logic external_reset_pin;
      logic boot_mode_pin;
      logic hw_watchdog_reset;
      logic sw_watchdog_reset;
      logic pll_supervisor_reset;
      logic spread_clock_supervisor_reset;
      logic profile_error_reset;
      logic sw_hard_reset;
      logic sw_reset;
      logic standby_transition_reset;
      logic power_domain_reset;
   } psrsc_rst_src_t;

   localparam int PSRSC_RST_W = 14;

   typedef enum logic [3:0] {
      PSRSC_RUN   = 4'h1,
      PSRSC_SLEEP = 4'h2,
      PSRSC_STOP  = 4'h4,
      PSRSC_TIMER = 4'h8
   } psrsc_mode_t;

   typedef enum logic [3:0] {
      PSRSC_CLS_NONE = 4'h1,
      PSRSC_CLS_1    = 4'h2,
      PSRSC_CLS_2    = 4'h4,
      PSRSC_CLS_3    = 4'h8
   } psrsc_cls_t;

endpackage : psrsc_pkg

// >>> src/psrsc_pin_ctrl.sv
// Operation
// (RL1) An enabled external interrupt keeps its pin's input buffer unblocked in every state.
// (RL2) In stop or timer standby with the domain-2 hold bit set, each pin keeps the state captured when the bit was set.
// (RL3) Without power-off and with the hold bit clear, pins keep their latest state in stop or timer standby.
// (RL4) Software sets the domain-2 hold bit before powering off domains 2 and 3.
// (RL5) With partial wake-up enabled, the pin drives as an output in standby instead of going high-impedance.
// (RL6) Power-on, RAM-retention low-voltage, supply low-voltage and reset-pin-with-mode-pin form reset class one.
// (RL7) The reset pin alone forms reset class two.
// (RL8) Watchdog, clock supervisor, profile error, software hard and software resets form reset class three.
// (RL9) Standby transition and power domain resets are an internal class apart from the three.
// (RL10) During a class one or two reset the pins are high-impedance with inputs blocked.
// (RL11) In sleep mode the pins keep their last state and function.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module psrsc_pin_ctrl
   import psrsc_pkg::*;
#(
   parameter int N_PINS = 16
)(
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   input  wire psrsc_rst_src_t      rst_src,
   input  wire psrsc_mode_t         pwr_mode,
   input  wire logic                pd2_power_off,
   input  wire logic [N_PINS-1:0]   core_out,
   input  wire logic [N_PINS-1:0]   core_oe,
   input  wire logic [N_PINS-1:0]   pin_in,
   output logic      [N_PINS-1:0]   pin_out,
   output logic      [N_PINS-1:0]   pin_oe,
   output logic      [N_PINS-1:0]   pin_in_core,
   output logic                     port_reset_b
);

   // ****************************************
   // Reset release and input synchronisers
   // ****************************************
   logic              rst_meta_reg;
   logic              rst_sync_b;
   psrsc_rst_src_t    src_meta_reg;
   psrsc_rst_src_t    src_sync_reg;
   logic [N_PINS-1:0] pin_meta_reg;
   logic [N_PINS-1:0] pin_sync_reg;

   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_b   <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_b   <= rst_meta_reg;
      end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         src_meta_reg <= '0;
         src_sync_reg <= '0;
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end
      else
      begin
         src_meta_reg <= rst_src;
         src_sync_reg <= src_meta_reg;
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
      end

   // ****************************************
   // Reset classification
   // ****************************************
   function automatic psrsc_cls_t classify(input psrsc_rst_src_t s);
      // (RL6) class one sources
      if (s.power_on_reset_src || s.ram_retention_lowv_reset || s.internal_supply_lowv_reset
          || (s.external_reset_pin && s.boot_mode_pin))
         return PSRSC_CLS_1;
      // (RL7) reset pin alone
      else if (s.external_reset_pin)
         return PSRSC_CLS_2;
      // (RL8) class three sources
      else if (s.hw_watchdog_reset || s.sw_watchdog_reset || s.pll_supervisor_reset
               || s.spread_clock_supervisor_reset || s.profile_error_reset || s.sw_hard_reset
               || s.sw_reset)
         return PSRSC_CLS_3;
      else
         return PSRSC_CLS_NONE;
   endfunction : classify

   psrsc_cls_t cls;
   logic       int_rst;
   assign cls = classify(src_sync_reg);
   // (RL9) internal class apart
   assign int_rst = src_sync_reg.standby_transition_reset || src_sync_reg.power_domain_reset;

   // ****************************************
   // Registers
   // ****************************************
   logic              hold_reg;
   logic              gate_reg;
   logic [N_PINS-1:0] eien_reg;
   logic [N_PINS-1:0] pwuen_reg;
   logic [3:0]        rst_seen_reg;

   always_ff @(posedge sys_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         hold_reg  <= 1'b0;
         gate_reg  <= 1'b0;
         eien_reg  <= '0;
         pwuen_reg <= '0;
      end
      else if (cls == PSRSC_CLS_1 || cls == PSRSC_CLS_2 || cls == PSRSC_CLS_3)
      begin
         gate_reg  <= 1'b0;
         eien_reg  <= '0;
         pwuen_reg <= '0;
         if (cls != PSRSC_CLS_3)
            hold_reg <= 1'b0;
      end
      else if (reg_wr)
         case (reg_addr)
            PSRSC_ADDR_CTRL:
            begin
               hold_reg <= reg_wdata[PSRSC_CTRL_HOLD];
               gate_reg <= reg_wdata[PSRSC_CTRL_GATE];
            end
            PSRSC_ADDR_EIEN:  eien_reg  <= reg_wdata[N_PINS-1:0];
            PSRSC_ADDR_PWUEN: pwuen_reg <= reg_wdata[N_PINS-1:0];
            default:          ;
         endcase

   // Sticky record of reset classes seen; set wins over write-one-to-clear
   always_ff @(posedge sys_clk or negedge rst_sync_b)
      if (!rst_sync_b)
         rst_seen_reg <= '0;
      else
      begin
         for (int i = 0; i < 4; i++)
            if ((i == 0 && cls == PSRSC_CLS_1) || (i == 1 && cls == PSRSC_CLS_2)
                || (i == 2 && cls == PSRSC_CLS_3) || (i == 3 && int_rst))
               rst_seen_reg[i] <= 1'b1;
            else if (reg_wr && reg_addr == PSRSC_ADDR_RSTSRC && reg_wdata[i])
               rst_seen_reg[i] <= 1'b0;
      end

   // ****************************************
   // Pin state capture
   // ****************************************
   logic              standby;
   logic              hold_rise;
   logic              hold_d_reg;
   logic [N_PINS-1:0] cap_out_reg;
   logic [N_PINS-1:0] cap_oe_reg;

   assign standby   = pwr_mode == PSRSC_STOP || pwr_mode == PSRSC_TIMER;
   assign hold_rise = hold_reg && !hold_d_reg;

   always_ff @(posedge sys_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         hold_d_reg  <= 1'b0;
         cap_out_reg <= '0;
         cap_oe_reg  <= '0;
      end
      else
      begin
         hold_d_reg <= hold_reg;
         // (RL2) snapshot taken when hold bit is set
         if (hold_rise)
         begin
            cap_out_reg <= pin_out;
            cap_oe_reg  <= pin_oe;
         end
         // (RL3) track latest state while hold is clear and awake
         else if (!hold_reg && !standby)
         begin
            cap_out_reg <= core_out;
            cap_oe_reg  <= core_oe & {N_PINS{gate_reg}};
         end
      end

   // ****************************************
   // Pin drive
   // ****************************************
   logic cls12;
   assign cls12 = cls == PSRSC_CLS_1 || cls == PSRSC_CLS_2;

   always_ff @(posedge sys_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         pin_out     <= '0;
         pin_oe      <= '0;
         pin_in_core <= '0;
      end
      else
      begin
         for (int i = 0; i < N_PINS; i++)
         begin
            // (RL10) high-impedance during class one, two or three
            if (cls12 || cls == PSRSC_CLS_3)
            begin
               pin_out[i] <= 1'b0;
               pin_oe[i]  <= 1'b0;
            end
            // (RL5) partial wake-up drives output
            else if (standby && pwuen_reg[i])
            begin
               pin_out[i] <= core_out[i];
               pin_oe[i]  <= 1'b1;
            end
            // (RL2) (RL3) standby keeps captured or latest state
            else if (standby)
            begin
               pin_out[i] <= cap_out_reg[i];
               pin_oe[i]  <= cap_oe_reg[i];
            end
            // (RL11) run and sleep follow port function
            else
            begin
               pin_out[i] <= core_out[i];
               pin_oe[i]  <= core_oe[i] & gate_reg;
            end
            // (RL1) external interrupt overrides input blocking
            pin_in_core[i] <= pin_sync_reg[i] & (eien_reg[i] | (!cls12 && !standby));
         end
      end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
      if (!rst_sync_b)
         port_reset_b <= 1'b0;
      else
         port_reset_b <= cls == PSRSC_CLS_NONE;

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_sync_b)
      if (!rst_sync_b)
         reg_rdata <= PSRSC_RDATA_RST;
      else if (reg_rd)
         case (reg_addr)
            PSRSC_ADDR_CTRL:   reg_rdata <= 32'({gate_reg, hold_reg});
            PSRSC_ADDR_EIEN:   reg_rdata <= 32'(eien_reg);
            PSRSC_ADDR_PWUEN:  reg_rdata <= 32'(pwuen_reg);
            PSRSC_ADDR_STATUS: reg_rdata <= 32'({pwr_mode, 3'h0, int_rst, cls == PSRSC_CLS_3,
                                                 cls == PSRSC_CLS_2, cls == PSRSC_CLS_1,
                                                 hold_reg && standby});
            PSRSC_ADDR_RSTSRC: reg_rdata <= 32'(rst_seen_reg);
            default:           reg_rdata <= PSRSC_RDATA_RST;
         endcase
      else
         reg_rdata <= PSRSC_RDATA_RST;

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_sync_b);

   a_eint_unblock: assert property (eien_reg[0] && !cls12 ##1 eien_reg[0] |-> pin_in_core[0] == $past(pin_sync_reg[0]))
      else $error("interrupt pin input blocked"); // (RL1)
   a_hold_keeps: assert property (hold_reg && $past(hold_reg) && standby && !pwuen_reg[0] && cls == PSRSC_CLS_NONE
                                  |=> pin_out[0] == $past(cap_out_reg[0]))
      else $error("held pin changed"); // (RL2)
   a_hold_snap: assert property (hold_rise |=> cap_out_reg == $past(pin_out))
      else $error("hold snapshot wrong"); // (RL2)
   a_last_state: assert property (!hold_reg && standby ##1 standby && !hold_reg |-> $stable(cap_oe_reg))
      else $error("latest state lost in standby"); // (RL3)
   a_pwu_out: assert property (standby && pwuen_reg[0] && cls == PSRSC_CLS_NONE |=> pin_oe[0])
      else $error("wake-up pin not driving"); // (RL5)
   a_cls1_map: assert property (src_sync_reg.power_on_reset_src |-> cls == PSRSC_CLS_1)
      else $error("class one misclassified"); // (RL6)
   a_cls2_map: assert property (src_sync_reg == psrsc_rst_src_t'(PSRSC_RST_W'(1) << 10) |-> cls == PSRSC_CLS_2)
      else $error("class two misclassified"); // (RL7)
   a_cls3_map: assert property (src_sync_reg.sw_reset && !src_sync_reg.external_reset_pin
                                && !src_sync_reg.power_on_reset_src |-> cls != PSRSC_CLS_NONE)
      else $error("class three missed"); // (RL8)
   a_int_sep: assert property (int_rst |=> rst_seen_reg[3])
      else $error("internal reset not recorded"); // (RL9)
   a_reset_hiz: assert property (cls12 |=> pin_oe == '0 ##1 (!cls12 || pin_oe == '0))
      else $error("pin driven during reset"); // (RL10)
   a_sleep_follow: assert property (pwr_mode == PSRSC_SLEEP && cls == PSRSC_CLS_NONE
                                    |=> pin_out == $past(core_out))
      else $error("sleep pin changed"); // (RL11)

   c_hold_standby: cover property (hold_rise ##[1:20] standby);
   c_pwu: cover property (standby && pwuen_reg != '0);
   c_cls2: cover property (cls == PSRSC_CLS_2);
   c_sleep: cover property (pwr_mode == PSRSC_SLEEP);

endmodule : psrsc_pin_ctrl

// >>> tb/psrsc_board.sv
`timescale 1ns/1ns
module psrsc_board
   import psrsc_pkg::*;
#(
   parameter int N_PINS = 16
)(
   input  wire logic [N_PINS-1:0] pin_out,
   input  wire logic [N_PINS-1:0] pin_oe,
   input  wire logic [N_PINS-1:0] ext_drv,
   output logic      [N_PINS-1:0] pin_in
);
   // Driven pads read back the device level, released pads carry the board level
   always_comb pin_in = (pin_out & pin_oe) | (ext_drv & ~pin_oe);
endmodule : psrsc_board

// >>> tb/psrsc_pin_ctrl_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module psrsc_pin_ctrl_tb;
   import psrsc_pkg::*;
   typedef struct packed {logic [13:0] src; logic [3:0] cls;} psrsc_row_t;
   logic           sys_clk, rst_b, reg_wr, reg_rd, pd2_power_off, port_reset_b;
   logic [7:0]     reg_addr;
   logic [31:0]    reg_wdata, reg_rdata, rd_val;
   psrsc_rst_src_t rst_src;
   psrsc_mode_t    pwr_mode;
   logic [15:0]    core_out, core_oe, pin_in, pin_out, pin_oe, pin_in_core, ext_drv;
   int             bad_count, cmp_count;
   // Source vector beside expected {internal, class3, class2, class1}
   psrsc_row_t     rows [14] = '{{14'h2000, 4'h1}, {14'h1000, 4'h1}, {14'h0800, 4'h1}, {14'h0600, 4'h1},
      {14'h0400, 4'h2}, {14'h0100, 4'h4}, {14'h0080, 4'h4}, {14'h0040, 4'h4}, {14'h0020, 4'h4},
      {14'h0010, 4'h4}, {14'h0008, 4'h4}, {14'h0004, 4'h4}, {14'h0002, 4'h8}, {14'h0001, 4'h8}};

   psrsc_pin_ctrl #(.N_PINS(16)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_src(rst_src),
      .pwr_mode(pwr_mode), .pd2_power_off(pd2_power_off), .core_out(core_out), .core_oe(core_oe),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_core(pin_in_core),
      .port_reset_b(port_reset_b));
   psrsc_board #(.N_PINS(16)) board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv), .pin_in(pin_in));

   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      // Data stand in the cycle after the strobe; take them at the edge that ends it
      @(posedge sys_clk);
      rd_val = reg_rdata;
   endtask : rd

   task automatic test_done;
      $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   initial
   begin
      #3000000;
      bad_count++;
      test_done();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0; rst_src = '0;
      pwr_mode = PSRSC_RUN; pd2_power_off = 1'b0; core_out = '0; core_oe = '0; ext_drv = 16'h5a5a;
      bad_count = 0; cmp_count = 0;
      cyc(3);
      `CHK(pin_oe, 16'h0000)
      rst_b <= 1'b1;
      cyc(3);
      rd(PSRSC_ADDR_STATUS); `CHK(rd_val, 32'h0000_0100)
      @(posedge sys_clk);
      `CHK(reg_rdata, 32'h0)
      rd(8'h3c); `CHK(rd_val, 32'h0)
      wr(PSRSC_ADDR_CTRL, 32'h2);
      rd(PSRSC_ADDR_CTRL); `CHK(rd_val, 32'h2)
      core_oe <= 16'hffff;
      core_out <= 16'h00ff;
      cyc(3);
      `CHK(pin_oe, 16'hffff)
      for (int i = 0; i < 14; i++)
      begin
         rst_src <= psrsc_rst_src_t'(rows[i].src);
         cyc(5);
         rd(PSRSC_ADDR_STATUS); `CHK(rd_val[4:1], rows[i].cls)
         `CHK(port_reset_b, rows[i].cls == 4'h8)
         if (rows[i].cls != 4'h8)
            `CHK(pin_oe, 16'h0000)
         rst_src <= '0;
         cyc(5);
         wr(PSRSC_ADDR_CTRL, 32'h2);
      end
      // Sticky class record, per-bit write-one-to-clear
      rd(PSRSC_ADDR_RSTSRC); `CHK(rd_val, 32'h0000_000f)
      wr(PSRSC_ADDR_RSTSRC, 32'h0000_0005);
      rd(PSRSC_ADDR_RSTSRC); `CHK(rd_val, 32'h0000_000a)
      // Control writes refused during a class two reset; a set beats a clear
      rst_src <= psrsc_rst_src_t'(14'h0400);
      cyc(5);
      wr(PSRSC_ADDR_CTRL, 32'h1);
      wr(PSRSC_ADDR_RSTSRC, 32'h0000_000f);
      rd(PSRSC_ADDR_CTRL); `CHK(rd_val, 32'h0)
      rd(PSRSC_ADDR_RSTSRC); `CHK(rd_val, 32'h0000_0002)
      rst_src <= '0;
      cyc(5);
      wr(PSRSC_ADDR_CTRL, 32'h2);
      core_oe <= 16'h0000;
      ext_drv <= 16'ha5c3;
      wr(PSRSC_ADDR_EIEN, 32'h00ff);
      pwr_mode <= PSRSC_STOP;
      cyc(5);
      `CHK(pin_in_core, 16'h00c3)
      wr(PSRSC_ADDR_PWUEN, 32'h0003);
      cyc(3);
      `CHK(pin_oe, 16'h0003)
      pwr_mode <= PSRSC_SLEEP;
      wr(PSRSC_ADDR_PWUEN, 32'h0);
      core_oe <= 16'hffff;
      core_out <= 16'hbeef;
      cyc(3);
      `CHK(pin_out, 16'hbeef)
      `CHK(pin_oe, 16'hffff)
      pwr_mode <= PSRSC_RUN;
      core_out <= 16'h9999;
      cyc(2);
      pwr_mode <= PSRSC_TIMER;
      cyc(1);
      core_out <= 16'h0f0f;
      cyc(4);
      `CHK(pin_out, 16'h9999)
      pwr_mode <= PSRSC_RUN;
      core_out <= 16'h1234;
      cyc(2);
      wr(PSRSC_ADDR_CTRL, 32'h3);
      cyc(3);
      core_out <= 16'h5678;
      cyc(2);
      pwr_mode <= PSRSC_STOP;
      pd2_power_off <= 1'b1;
      cyc(4);
      `CHK(pin_out, 16'h1234)
      rd(PSRSC_ADDR_STATUS); `CHK(rd_val[PSRSC_ST_HELD], 1'b1)
      rst_b <= 1'b0;
      cyc(2);
      `CHK(pin_out, 16'h0000)
      rst_b <= 1'b1;
      pwr_mode <= PSRSC_RUN;
      pd2_power_off <= 1'b0;
      cyc(3);
      rd(PSRSC_ADDR_CTRL); `CHK(rd_val, 32'h0)
      test_done();
   end
endmodule : psrsc_pin_ctrl_tb
